// >>> host_pin_model.sv
`timescale 1ns/100ps
module host_pin_model (
   // Pin from the device
   input  wire logic pin_o,
   input  wire logic pin_oe,
   // Level seen by the host
   output logic      level
);
   // Board pull-up holds a shared line high while nobody drives
   assign level = pin_oe ? pin_o : 1'b1;
endmodule : host_pin_model

// >>> pin_drive.sv
`timescale 1ns/100ps
module pin_drive (
   // Control
   input  wire logic polarity,
   input  wire logic drive_when_asserted,
   input  wire logic drive_enable,
   // Signal in
   input  wire logic sig,
   // Pin
   output logic      pin_o,
   output logic      pin_oe
);
   logic level;

   assign level = sig ^ polarity;
   assign pin_o = level;
   // Shared-line mode drives only the asserted level
   assign pin_oe = drive_enable & (~drive_when_asserted | sig);

endmodule : pin_drive

// >>> tb.sv
`timescale 1ns/100ps
module tb;
   logic        clk_sys = 0, srst = 1, wr = 0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata;
   logic [13:0] ev = '0;
   logic        p1o, p1e, p2o, p2e, l1, l2;
   int          fail_count = 0, samples_checked = 0;
   always #4 clk_sys = ~clk_sys;
   timing_signal_output_mux i_timing_signal_output_mux (.CLK_SYS(clk_sys), .SRST(srst), .REG_WR(wr),
      .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .IRQ_IN(ev[0]), .NORMAL_MODE(ev[1]),
      .SLOT_A_EN(ev[2]), .SLOT_B_EN(ev[3]), .SLOT_A_START(ev[4]), .SLOT_A_END(ev[5]), .SLOT_B_START(ev[6]),
      .SLOT_B_END(ev[7]), .SAMPLE_START(ev[8]), .SLOT_A_WRITTEN(ev[9]), .SLOT_B_WRITTEN(ev[10]),
      .LED_PULSE_A(ev[11]), .LED_PULSE_B(ev[12]), .OSC_SLOW(ev[13]), .TIMING_PIN_FIRST_O(p1o),
      .TIMING_PIN_FIRST_OE(p1e), .TIMING_PIN_SECOND_O(p2o), .TIMING_PIN_SECOND_OE(p2e));
   host_pin_model i_host_pin_model_first (.pin_o(p1o), .pin_oe(p1e), .level(l1));
   host_pin_model i_host_pin_model_second (.pin_o(p2o), .pin_oe(p2e), .level(l2));
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : tick
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      addr = a;
      wdata = d;
      wr = 1;
      tick(1);
      wr = 0;
   endtask : wreg
   // Pulse one event input, then look at the first pin after the pipeline settles
   task automatic step(input int b, input logic exp);
      ev[b] = 1;
      tick(1);
      ev[b] = 0;
      tick(3);
      chk("first pin", {15'h0, l1}, {15'h0, exp});
   endtask : step
   task automatic t_regs();
      logic [7:0] a[3] = '{8'h02, 8'h0b, 8'h4f};
      foreach (a[i]) begin
         addr = a[i];
         tick(1);
         chk("reset value", rdata, 16'h0000);
         wreg(a[i], 16'h1f07);
         chk("readback", rdata, 16'h1f07);
      end
      addr = 8'h03;
      tick(1);
      chk("unmapped read", rdata, 16'h0000);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_const();
      for (int p = 0; p < 2; p++) begin
         wreg(8'h02, 16'h0004 | (p[0] ? 16'h0101 : 16'h0000));
         wreg(8'h4f, 16'h0040);
         wreg(8'h0b, 16'h1011);
         tick(3);
         chk("first one", {15'h0, p1o}, {15'h0, ~p[0]});
         chk("second zero", {15'h0, p2o}, {15'h0, p[0]});
         chk("both drive", {14'h0, p1e, p2e}, 16'h0003);
         wreg(8'h0b, 16'h0310);
         tick(3);
         chk("first zero", {15'h0, l1}, {15'h0, p[0]});
         chk("spare code", {15'h0, l2}, {15'h0, p[0]});
      end
      $display("t_const done");
   endtask : t_const
   task automatic t_drive();
      wreg(8'h02, 16'h0206);
      wreg(8'h0b, 16'h1011);
      tick(3);
      chk("asserted drive", {14'h0, p1e, p2e}, 16'h0002);
      chk("pulled up", {15'h0, l2}, 16'h0001);
      wreg(8'h02, 16'h0200);
      wreg(8'h4f, 16'h0000);
      tick(1);
      chk("disabled", {14'h0, p1e, p2e}, 16'h0000);
      $display("t_drive done");
   endtask : t_drive
   task automatic t_route();
      logic [4:0] c[6] = '{5'h01, 5'h05, 5'h06, 5'h07, 5'h07, 5'h13};
      int         b[6] = '{0, 11, 12, 11, 12, 13};
      wreg(8'h02, 16'h0004);
      wreg(8'h4f, 16'h0040);
      foreach (c[i]) begin
         wreg(8'h0b, {3'h0, c[i], 3'h0, c[i]});
         ev[b[i]] = 1;
         tick(6);
         chk("source high", {14'h0, l1, l2}, 16'h0003);
         ev[b[i]] = 0;
         tick(6);
         chk("source low", {14'h0, l1, l2}, 16'h0000);
      end
      $display("t_route done");
   endtask : t_route
   task automatic t_seq();
      logic [4:0] c[3] = '{5'h0c, 5'h0d, 5'h0e};
      int         b[3] = '{9, 10, 10};
      ev[3:1] = 3'b111;
      wreg(8'h0b, 16'h0002);
      step(4, 1);
      step(5, 1);
      step(7, 0);
      ev[3] = 0;
      step(4, 1);
      step(5, 0);
      foreach (c[i]) begin
         wreg(8'h0b, {11'h0, c[i]});
         step(b[i], 1);
         step(8, 0);
      end
      wreg(8'h0b, 16'h000f);
      ev[1] = 0;
      tick(1);
      ev[1] = 1;
      step(8, 0);
      step(5, 1);
      step(5, 0);
      $display("t_seq done");
   endtask : t_seq
   task automatic conclude();
      $display("Checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude
   initial begin
      tick(10);
      srst = 0;
      t_regs();
      t_const();
      t_drive();
      t_route();
      t_seq();
      conclude();
   end
endmodule : tb

// >>> timing_mux_monitor.sv
`timescale 1ns/100ps
module timing_mux_monitor (
   // Clock and reset
   input wire logic        CLK_SYS,
   input wire logic        SRST,
   // Register port
   input wire logic        REG_WR,
   input wire logic [7:0]  REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic [15:0] REG_RDATA,
   // Pins
   input wire logic        TIMING_PIN_FIRST_O,
   input wire logic        TIMING_PIN_FIRST_OE,
   input wire logic        TIMING_PIN_SECOND_O,
   input wire logic        TIMING_PIN_SECOND_OE
);
   logic [15:0] ctl_r, sel_r, cfg_r;
   logic [4:0]  f_sel, s_sel;
   // Shadow copies, so pin checks follow the programmed state
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ctl_r <= 16'h0000;
         sel_r <= 16'h0000;
         cfg_r <= 16'h0000;
      end else if (REG_WR) begin
         if (REG_ADDR == 8'h02) ctl_r <= REG_WDATA;
         if (REG_ADDR == 8'h0b) sel_r <= REG_WDATA;
         if (REG_ADDR == 8'h4f) cfg_r <= REG_WDATA;
      end
   end
   assign f_sel = sel_r[4:0];
   assign s_sel = sel_r[12:8];
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   sel_readback_a: assert property ((REG_WR && REG_ADDR == 8'h0b) ##1 (REG_ADDR == 8'h0b)
      |-> REG_RDATA == $past(REG_WDATA)) else $error("select readback wrong");
   first_off_a: assert property (!ctl_r[2] |-> !TIMING_PIN_FIRST_OE) else $error("first pin drives");
   second_off_a: assert property (!cfg_r[6] |-> !TIMING_PIN_SECOND_OE) else $error("second pin drives");
   push_pull_a: assert property (ctl_r[2] && !ctl_r[1] |-> TIMING_PIN_FIRST_OE) else $error("push-pull off");
   one_level_a: assert property (f_sel == 5'h11 && $past(f_sel) == 5'h11 && $past(f_sel, 2) == 5'h11
      |-> TIMING_PIN_FIRST_O == !ctl_r[0]) else $error("constant one wrong");
   zero_level_a: assert property (s_sel == 5'h10 && $past(s_sel) == 5'h10 && $past(s_sel, 2) == 5'h10
      |-> TIMING_PIN_SECOND_O == ctl_r[8]) else $error("constant zero wrong");
   idle_float_a: assert property (ctl_r[9] && s_sel == 5'h10 && $past(s_sel) == 5'h10 && $past(s_sel, 2) == 5'h10
      |-> !TIMING_PIN_SECOND_OE) else $error("idle pin drives");
   spare_code_a: assert property (s_sel == 5'h03 && $past(s_sel) == 5'h03 && $past(s_sel, 2) == 5'h03
      |-> TIMING_PIN_SECOND_O == ctl_r[8]) else $error("spare code active");
endmodule : timing_mux_monitor
bind timing_signal_output_mux timing_mux_monitor i_timing_mux_monitor (.CLK_SYS, .SRST, .REG_WR, .REG_ADDR,
   .REG_WDATA, .REG_RDATA, .TIMING_PIN_FIRST_O, .TIMING_PIN_FIRST_OE, .TIMING_PIN_SECOND_O, .TIMING_PIN_SECOND_OE);

// >>> timing_mux_pkg.sv
package timing_mux_pkg;

   // Register indices, 16-bit data
   localparam logic [7:0] ADDR_PIN_CTRL   = 8'h02;
   localparam logic [7:0] ADDR_TIMING_SEL = 8'h0b;
   localparam logic [7:0] ADDR_PIN2_CFG   = 8'h4f;

   // Pin control field positions; EN_SECOND is in the second pin drive configuration register
   localparam int POL_FIRST   = 0;
   localparam int MODE_FIRST  = 1;
   localparam int EN_FIRST    = 2;
   localparam int POL_SECOND  = 8;
   localparam int MODE_SECOND = 9;
   localparam int EN_SECOND   = 6;

   // Select field positions
   localparam int SEL_FIRST_LSB  = 0;
   localparam int SEL_SECOND_LSB = 8;
   localparam int SEL_W          = 5;

   // Reset values
   localparam logic [15:0] PIN_CTRL_RST   = 16'h0000;
   localparam logic [15:0] TIMING_SEL_RST = 16'h0000;
   localparam logic [15:0] PIN2_CFG_RST   = 16'h0000;

   // Source selection codes
   localparam logic [4:0] SRC_IRQ      = 5'h01;
   localparam logic [4:0] SRC_WINDOW   = 5'h02;
   localparam logic [4:0] SRC_LED_A    = 5'h05;
   localparam logic [4:0] SRC_LED_B    = 5'h06;
   localparam logic [4:0] SRC_LED_AB   = 5'h07;
   localparam logic [4:0] SRC_WR_A     = 5'h0c;
   localparam logic [4:0] SRC_WR_B     = 5'h0d;
   localparam logic [4:0] SRC_WR_AB    = 5'h0e;
   localparam logic [4:0] SRC_HALF     = 5'h0f;
   localparam logic [4:0] SRC_ZERO     = 5'h10;
   localparam logic [4:0] SRC_ONE      = 5'h11;
   localparam logic [4:0] SRC_OSC      = 5'h13;

endpackage : timing_mux_pkg

// >>> timing_signal_output_mux.sv
`timescale 1ns/100ps
module timing_signal_output_mux (
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        SRST,
   // Register port
   input  wire logic        REG_WR,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [15:0] REG_WDATA,
   output logic      [15:0] REG_RDATA,
   // Device interrupt, already masked
   input  wire logic        IRQ_IN,
   // Sequencer events, on CLK_SYS
   input  wire logic        NORMAL_MODE,
   input  wire logic        SLOT_A_EN,
   input  wire logic        SLOT_B_EN,
   input  wire logic        SLOT_A_START,
   input  wire logic        SLOT_A_END,
   input  wire logic        SLOT_B_START,
   input  wire logic        SLOT_B_END,
   input  wire logic        SAMPLE_START,
   input  wire logic        SLOT_A_WRITTEN,
   input  wire logic        SLOT_B_WRITTEN,
   input  wire logic        LED_PULSE_A,
   input  wire logic        LED_PULSE_B,
   // Sample oscillator, asynchronous
   input  wire logic        OSC_SLOW,
   // Output pins
   output logic             TIMING_PIN_FIRST_O,
   output logic             TIMING_PIN_FIRST_OE,
   output logic             TIMING_PIN_SECOND_O,
   output logic             TIMING_PIN_SECOND_OE
);

   // Register targets after address decode
   typedef enum {
      TGT_NONE,
      TGT_PIN_CTRL,
      TGT_TIMING_SEL,
      TGT_PIN2_CFG
   } reg_target_t;

   // Register state
   logic [15:0] pin_ctrl_r;
   logic [15:0] timing_sel_r;
   logic [15:0] pin2_cfg_r;
   reg_target_t target;

   // Per-pin controls split out of the registers
   logic [4:0]  sel_first;
   logic [4:0]  sel_second;
   logic        pol_first;
   logic        pol_second;
   logic        mode_first;
   logic        mode_second;
   logic        en_first;
   logic        en_second;

   // Sequencer state
   logic        window_r;
   logic        window_nxt;
   logic        wr_a_r;
   logic        wr_b_r;
   logic        half_r;
   logic        normal_d_r;
   logic        normal_rise;
   logic        sample_done;

   // Oscillator synchroniser
   logic        osc_meta_r;
   logic        osc_sync_r;

   // Selected signals, before polarity
   logic        sig_first_r;
   logic        sig_second_r;

   // Write and read paths share one decode so they never disagree
   function automatic reg_target_t decode_reg(input logic [7:0] addr);
      reg_target_t t;
      t = TGT_NONE;
      case (addr)
         timing_mux_pkg::ADDR_PIN_CTRL   : t = TGT_PIN_CTRL;
         timing_mux_pkg::ADDR_TIMING_SEL : t = TGT_TIMING_SEL;
         timing_mux_pkg::ADDR_PIN2_CFG   : t = TGT_PIN2_CFG;
         default                         : t = TGT_NONE;
      endcase
      return t;
   endfunction : decode_reg

   // Start of the first enabled slot of a sample
   function automatic logic first_slot_start(input logic a_en,
                                             input logic b_en,
                                             input logic a_start,
                                             input logic b_start);
      return (a_en & a_start) | (~a_en & b_en & b_start);
   endfunction : first_slot_start

   // End of the last enabled slot, which also ends the sample
   function automatic logic last_slot_end(input logic a_en,
                                          input logic b_en,
                                          input logic a_end,
                                          input logic b_end);
      return (b_en & b_end) | (~b_en & a_en & a_end);
   endfunction : last_slot_end

   // Shared decoder: one function keeps both pins identical in meaning
   function automatic logic pick_source(input logic [4:0] code,
                                        input logic       irq,
                                        input logic       win,
                                        input logic       la,
                                        input logic       lb,
                                        input logic       wa,
                                        input logic       wb,
                                        input logic       half,
                                        input logic       osc);
      logic r;
      r = 1'b0;
      case (code)
         timing_mux_pkg::SRC_IRQ    : r = irq;
         timing_mux_pkg::SRC_WINDOW : r = win;
         timing_mux_pkg::SRC_LED_A  : r = la;
         timing_mux_pkg::SRC_LED_B  : r = lb;
         timing_mux_pkg::SRC_LED_AB : r = la | lb;
         timing_mux_pkg::SRC_WR_A   : r = wa;
         timing_mux_pkg::SRC_WR_B   : r = wb;
         timing_mux_pkg::SRC_WR_AB  : r = wa | wb;
         timing_mux_pkg::SRC_HALF   : r = half;
         timing_mux_pkg::SRC_ZERO   : r = 1'b0;
         timing_mux_pkg::SRC_ONE    : r = 1'b1;
         timing_mux_pkg::SRC_OSC    : r = osc;
         default                    : r = 1'b0;
      endcase
      return r;
   endfunction : pick_source

   // Field split
   assign target      = decode_reg(REG_ADDR);
   assign sel_first   = timing_sel_r[timing_mux_pkg::SEL_FIRST_LSB +: timing_mux_pkg::SEL_W];
   assign sel_second  = timing_sel_r[timing_mux_pkg::SEL_SECOND_LSB +: timing_mux_pkg::SEL_W];
   assign pol_first   = pin_ctrl_r[timing_mux_pkg::POL_FIRST];
   assign pol_second  = pin_ctrl_r[timing_mux_pkg::POL_SECOND];
   assign mode_first  = pin_ctrl_r[timing_mux_pkg::MODE_FIRST];
   assign mode_second = pin_ctrl_r[timing_mux_pkg::MODE_SECOND];
   assign en_first    = pin_ctrl_r[timing_mux_pkg::EN_FIRST];
   // Second pin enable lives in a different register
   assign en_second   = pin2_cfg_r[timing_mux_pkg::EN_SECOND];

   // Pin control register
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         pin_ctrl_r <= timing_mux_pkg::PIN_CTRL_RST;
      end else if (REG_WR && (target == TGT_PIN_CTRL)) begin
         pin_ctrl_r <= REG_WDATA;
      end
   end

   // Timing select register
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         timing_sel_r <= timing_mux_pkg::TIMING_SEL_RST;
      end else if (REG_WR && (target == TGT_TIMING_SEL)) begin
         timing_sel_r <= REG_WDATA;
      end
   end

   // Second pin drive configuration register
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         pin2_cfg_r <= timing_mux_pkg::PIN2_CFG_RST;
      end else if (REG_WR && (target == TGT_PIN2_CFG)) begin
         pin2_cfg_r <= REG_WDATA;
      end
   end

   // Read-back, unmapped index reads zero
   always_comb begin
      case (target)
         TGT_PIN_CTRL   : REG_RDATA = pin_ctrl_r;
         TGT_TIMING_SEL : REG_RDATA = timing_sel_r;
         TGT_PIN2_CFG   : REG_RDATA = pin2_cfg_r;
         default        : REG_RDATA = 16'h0000;
      endcase
   end

   // Sample window: opens at first enabled slot, closes after last
   always_comb begin
      window_nxt = window_r;
      if (first_slot_start(SLOT_A_EN, SLOT_B_EN, SLOT_A_START, SLOT_B_START)) begin
         window_nxt = 1'b1;
      end else if (last_slot_end(SLOT_A_EN, SLOT_B_EN, SLOT_A_END, SLOT_B_END)) begin
         window_nxt = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         window_r <= 1'b0;
      end else begin
         window_r <= window_nxt;
      end
   end

   // Slot A data-written flag; a write in the start cycle wins over the clear
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         wr_a_r <= 1'b0;
      end else if (SLOT_A_WRITTEN) begin
         wr_a_r <= 1'b1;
      end else if (SAMPLE_START) begin
         wr_a_r <= 1'b0;
      end
   end

   // Slot B data-written flag, same priority
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         wr_b_r <= 1'b0;
      end else if (SLOT_B_WRITTEN) begin
         wr_b_r <= 1'b1;
      end else if (SAMPLE_START) begin
         wr_b_r <= 1'b0;
      end
   end

   // Mode history; resets low so a mode already on at release counts as entry
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         normal_d_r <= 1'b0;
      end else begin
         normal_d_r <= NORMAL_MODE;
      end
   end

   assign normal_rise = NORMAL_MODE & ~normal_d_r;
   assign sample_done = NORMAL_MODE & last_slot_end(SLOT_A_EN, SLOT_B_EN, SLOT_A_END, SLOT_B_END);

   // Half-rate toggle, reset low on entry to normal mode
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         half_r <= 1'b0;
      end else if (normal_rise) begin
         half_r <= 1'b0;
      end else if (sample_done) begin
         half_r <= ~half_r;
      end
   end

   // Oscillator copy passes two flops; it lags by up to two cycles
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         osc_meta_r <= 1'b0;
      end else begin
         osc_meta_r <= OSC_SLOW;
      end
   end

   // Only this flop may read the first stage
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         osc_sync_r <= 1'b0;
      end else begin
         osc_sync_r <= osc_meta_r;
      end
   end

   // Selected signals registered so pin data comes from flops
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         sig_first_r <= 1'b0;
      end else begin
         sig_first_r <= pick_source(sel_first,
                                    IRQ_IN,
                                    window_r,
                                    LED_PULSE_A,
                                    LED_PULSE_B,
                                    wr_a_r,
                                    wr_b_r,
                                    half_r,
                                    osc_sync_r);
      end
   end

   // Independent field, same sources: both pins may show one signal
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         sig_second_r <= 1'b0;
      end else begin
         sig_second_r <= pick_source(sel_second,
                                     IRQ_IN,
                                     window_r,
                                     LED_PULSE_A,
                                     LED_PULSE_B,
                                     wr_a_r,
                                     wr_b_r,
                                     half_r,
                                     osc_sync_r);
      end
   end

   // Polarity sets the pin level; mode and enable decide from the signal before polarity whether the pin drives
   pin_drive u_first (
      .polarity            (pol_first),
      .drive_when_asserted (mode_first),
      .drive_enable        (en_first),
      .sig                 (sig_first_r),
      .pin_o               (TIMING_PIN_FIRST_O),
      .pin_oe              (TIMING_PIN_FIRST_OE)
   );

   pin_drive u_second (
      .polarity            (pol_second),
      .drive_when_asserted (mode_second),
      .drive_enable        (en_second),
      .sig                 (sig_second_r),
      .pin_o               (TIMING_PIN_SECOND_O),
      .pin_oe              (TIMING_PIN_SECOND_OE)
   );

endmodule : timing_signal_output_mux
